// ==== src/cpu_powerup_reset_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module cpu_powerup_reset_sequencer (
   // clock and reset
   input wire logic mclk,
   input wire logic srst,
   // board pins, asynchronous
   input wire logic supplies_good,
   input wire logic proc_reset_n,
   input wire logic bus_connect,
   input wire logic pll_lock_raw,
   // fused codes, same clock
   input wire logic [pwrseq_pkg::RATIO_W-1:0] ratio_fuse,
   input wire logic [pwrseq_pkg::VOLT_W-1:0] volt_fuse,
   // open-drain code pins, oe_n low pulls the pin low
   output logic [pwrseq_pkg::RATIO_W-1:0] freq_ratio_code_oe_n,
   output logic [pwrseq_pkg::VOLT_W-1:0] core_volt_code_oe_n,
   // clock grid control
   output logic grid_on_pll,
   output logic core_hold,
   // init packet handshake
   output logic proc_ready_flag,
   output logic fwd_clk_init,
   output logic init_packet_start
);
   import pwrseq_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic [PIN_N-1:0] s1_r;
   logic [PIN_N-1:0] s2_r;
   logic [PIN_N-1:0] s3_r;
   logic [PIN_N-1:0] pin_q_r;
   logic [PIN_N-1:0] pin_q_nxt;

   // a level counts only once the second and third stages agree
   function automatic logic [PIN_N-1:0] settle(input logic [PIN_N-1:0] a,
                                               input logic [PIN_N-1:0] b,
                                               input logic [PIN_N-1:0] prev);
      settle = (a & b) | (prev & (a ^ b));
   endfunction

   // three-stage chain, first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (srst) begin
         s1_r <= PIN_RST_VAL;
         s2_r <= PIN_RST_VAL;
         s3_r <= PIN_RST_VAL;
      end else begin
         s1_r <= {pll_lock_raw, bus_connect, proc_reset_n, supplies_good};
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign pin_q_nxt = settle(s2_r, s3_r, pin_q_r);

   // filtered pin levels
   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_q_r <= PIN_RST_VAL;
      end else begin
         pin_q_r <= pin_q_nxt;
      end
   end

   logic good_q;
   logic rst_q;
   logic conn_q;
   logic lock_q;
   logic conn_prev_r;
   logic rst_prev_r;

   assign good_q = pin_q_r[PIN_GOOD];
   assign rst_q = ~pin_q_r[PIN_RST_N];
   assign conn_q = pin_q_r[PIN_CONNECT];
   assign lock_q = pin_q_r[PIN_LOCK];

   // edge history of filtered levels
   always_ff @(posedge mclk) begin
      if (srst) begin
         conn_prev_r <= 1'b0;
         rst_prev_r <= 1'b1;
      end else begin
         conn_prev_r <= conn_q;
         rst_prev_r <= rst_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock grid state

   grid_state_t grid_r;
   grid_state_t grid_nxt;

   // one-way walk: a sagging supply-good never sends us back to the ring
   always_comb begin
      grid_nxt = grid_r;
      case (grid_r)
         GRID_RING: begin
            if (good_q) begin
               grid_nxt = GRID_LOCK_WAIT;
            end
         end
         GRID_LOCK_WAIT: begin
            if (lock_q) begin
               grid_nxt = GRID_PLL_RUN;
            end
         end
         GRID_PLL_RUN: begin
            grid_nxt = GRID_PLL_RUN;
         end
         default: begin
            grid_nxt = GRID_RING;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         grid_r <= GRID_RING;
      end else begin
         grid_r <= grid_nxt;
      end
   end

   // grid source and core hold straight from flops
   always_ff @(posedge mclk) begin
      if (srst) begin
         grid_on_pll <= 1'b0;
         core_hold <= 1'b1;
      end else begin
         grid_on_pll <= (grid_nxt != GRID_RING);
         core_hold <= rst_q | (grid_nxt != GRID_PLL_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // code pins

   // ratio code is driven from reset onward, so it is already valid when
   // supply-good or the reset pin arrive; no sync latency can make it late
   always_ff @(posedge mclk) begin
      if (srst) begin
         freq_ratio_code_oe_n <= RATIO_RST_VAL;
      end else begin
         freq_ratio_code_oe_n <= ratio_fuse;
      end
   end

   // voltage code frozen once the core runs on the PLL, so the regulator
   // never sees the target move under a live core
   always_ff @(posedge mclk) begin
      if (srst) begin
         core_volt_code_oe_n <= VOLT_RST_VAL;
      end else if (grid_r == GRID_RING) begin
         core_volt_code_oe_n <= volt_fuse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // init packet handshake

   logic conn_rise;
   logic rst_fall;

   assign conn_rise = conn_q & ~conn_prev_r;
   assign rst_fall = rst_prev_r & ~rst_q;

   // start pulse only for a connect rise after reset release; connect held
   // high across the release is the bridge reset overlap, not a packet
   always_ff @(posedge mclk) begin
      if (srst) begin
         init_packet_start <= 1'b0;
      end else begin
         init_packet_start <= conn_rise & ~rst_q & ~rst_prev_r;
      end
   end

   // ready follows reset and PLL state, forward clock init follows reset alone
   always_ff @(posedge mclk) begin
      if (srst) begin
         proc_ready_flag <= 1'b0;
         fwd_clk_init <= 1'b1;
      end else begin
         proc_ready_flag <= ~rst_q & (grid_nxt == GRID_PLL_RUN);
         fwd_clk_init <= rst_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   localparam int code_lim = CODE_VALID_CYC;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   chk_ratio_after_good: assert property (
      $rose(good_q) |-> ##[0:code_lim] (freq_ratio_code_oe_n == $past(ratio_fuse)))
      else $error("ratio code not valid after supply good");

   chk_ratio_after_reset: assert property (
      $rose(rst_q) |-> ##[0:code_lim] (freq_ratio_code_oe_n == $past(ratio_fuse)))
      else $error("ratio code not valid after reset");

   chk_grid_to_pll: assert property (
      (grid_r == GRID_RING && good_q) |-> ##1 grid_on_pll)
      else $error("grid did not move to pll");

   chk_grid_ring_hold: assert property (
      (grid_r == GRID_RING && !good_q) |-> ##1 !grid_on_pll)
      else $error("grid left ring before supply good");

   chk_grid_no_return: assert property (
      grid_on_pll |=> grid_on_pll)
      else $error("grid switched back to ring");

   chk_volt_frozen: assert property (
      (grid_r != GRID_RING) |=> $stable(core_volt_code_oe_n))
      else $error("voltage code moved after supply good");

   chk_packet_start: assert property (
      (conn_rise && !rst_q && !rst_prev_r) |=> init_packet_start)
      else $error("connect after reset did not start packet");

   chk_no_packet_reset: assert property (
      rst_q |=> !init_packet_start)
      else $error("packet start during reset");

   chk_fwd_init: assert property (
      rst_q |=> (fwd_clk_init && !proc_ready_flag))
      else $error("handshake active during reset");

   cov_cold_boot: cover property ($rose(good_q) ##[1:50] (grid_r == GRID_PLL_RUN));
   cov_overlap: cover property (rst_q && conn_q ##[1:50] rst_fall);
   cov_packet: cover property (init_packet_start);
   cov_ready: cover property ($rose(proc_ready_flag));

endmodule

`default_nettype wire

// ==== src/pwrseq_pkg.sv ====
// Function
// - all supplies good before supply-good; core supply follows our voltage code
// - ring oscillator clocks the core until supply-good, then grid moves to PLL
// - after first supply-good, never switch clock source again
// - connect rising only after reset release starts an init packet transfer
// - frequency-ratio code valid within 100 ns after supply-good; chipset waits
// - frequency-ratio code valid within 100 ns after reset input asserts
// - init packet uses ready, connect and forward-clock-init, all on reference clock
package pwrseq_pkg;

   // clock rate and timing
   localparam int CLK_MHZ = 20;
   localparam int T_CODE_VALID_NS = 100;
   // longest time, rounds down, never below one cycle
   localparam int CODE_VALID_CYC_RAW = (T_CODE_VALID_NS * CLK_MHZ) / 1000;
   localparam int CODE_VALID_CYC = (CODE_VALID_CYC_RAW < 1) ? 1 : CODE_VALID_CYC_RAW;

   // field widths
   localparam int RATIO_W = 4;
   localparam int VOLT_W = 5;
   localparam int PIN_N = 4;

   // pin synchroniser lanes
   localparam int PIN_GOOD = 0;
   localparam int PIN_RST_N = 1;
   localparam int PIN_CONNECT = 2;
   localparam int PIN_LOCK = 3;

   // reset values
   localparam logic [PIN_N-1:0] PIN_RST_VAL = 4'h0; // reset pin reads asserted
   localparam logic [RATIO_W-1:0] RATIO_RST_VAL = 4'hF;
   localparam logic [VOLT_W-1:0] VOLT_RST_VAL = 5'h1F;

   // clock grid sequencing, gray along ring -> wait -> run
   typedef enum logic [1:0] {
      GRID_RING = 2'b00,
      GRID_LOCK_WAIT = 2'b01,
      GRID_PLL_RUN = 2'b11
   } grid_state_t;

endpackage

// ==== tb/board_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module board_model (
   // clock and control
   input wire logic mclk,
   input wire logic go,
   input wire logic drop,
   // board pins
   output logic supplies_good,
   output logic proc_reset_n,
   output logic bus_connect,
   output logic pll_lock_raw
);
   int cnt = 0;
   logic booted = 1'b0;

   ////////////////////////////////////////////////////////////
   // free board time base, intervals scaled to a few cycles
   always @(posedge mclk) cnt <= go ? cnt + 1 : 0;
   // reset low from the start, good rises later; drop breaks monotony on purpose
   assign supplies_good = (cnt >= 2) && !drop;
   assign pll_lock_raw = cnt >= 6;
   // reset held well past good, as on a cold boot
   assign proc_reset_n = cnt >= 14;
   // once booted, a warm reset takes the bridge reset along, so connect stays high
   always @(posedge mclk) if (cnt >= 14) booted <= 1'b1;
   // bridge connect overlaps reset, later rise opens a packet
   assign bus_connect = (cnt >= 4 && cnt < 20) || cnt >= 30 || (booted && cnt < 4);
endmodule

`default_nettype wire

// ==== tb/tb_cpu_powerup_reset_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_cpu_powerup_reset_sequencer;
   import pwrseq_pkg::*;
   typedef struct packed {
      logic [3:0] ratio;
      logic [4:0] volt;
      logic [3:0] ratio_exp;
      logic [4:0] volt_exp;
   } row_t;
   logic mclk = 0, srst = 1, go = 0, drop = 0;
   logic supplies_good, proc_reset_n, bus_connect, pll_lock_raw;
   logic [RATIO_W-1:0] ratio_fuse = 4'h0;
   logic [VOLT_W-1:0] volt_fuse = 5'h00;
   logic [RATIO_W-1:0] ratio_oe_n;
   logic [VOLT_W-1:0] volt_oe_n;
   logic grid_on_pll, core_hold, proc_ready_flag, fwd_clk_init, init_packet_start;
   logic [4:0] status;
   assign status = {grid_on_pll, core_hold, proc_ready_flag, fwd_clk_init, init_packet_start};
   int mismatches = 0, cmp_count = 0, pulses = 0, early = 0;
   row_t rows [4] = '{'{4'h0, 5'h00, 4'h0, 5'h00}, '{4'hF, 5'h1F, 4'hF, 5'h1F},
                      '{4'hA, 5'h15, 4'hA, 5'h15}, '{4'h5, 5'h0A, 4'h5, 5'h0A}};

   always #25 mclk = ~mclk;

   cpu_powerup_reset_sequencer u_dut (.mclk(mclk), .srst(srst),
      .supplies_good(supplies_good), .proc_reset_n(proc_reset_n),
      .bus_connect(bus_connect), .pll_lock_raw(pll_lock_raw),
      .ratio_fuse(ratio_fuse), .volt_fuse(volt_fuse),
      .freq_ratio_code_oe_n(ratio_oe_n), .core_volt_code_oe_n(volt_oe_n),
      .grid_on_pll(grid_on_pll), .core_hold(core_hold),
      .proc_ready_flag(proc_ready_flag), .fwd_clk_init(fwd_clk_init),
      .init_packet_start(init_packet_start));

   board_model u_board (.mclk(mclk), .go(go), .drop(drop),
      .supplies_good(supplies_good), .proc_reset_n(proc_reset_n),
      .bus_connect(bus_connect), .pll_lock_raw(pll_lock_raw));

   ////////////////////////////////////////////////////////////
   // packet starts, and any seen before the core is let go
   always @(posedge mclk) begin
      if (!srst && init_packet_start === 1'b1) begin
         pulses++;
         if (proc_ready_flag !== 1'b1) early++;
      end
   end

   task automatic chk(input logic [4:0] got, input logic [4:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic complete_run;
      $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   // watchdog, the whole run needs about 86 cycles
   initial begin
      #(400 * 50);
      mismatches++;
      complete_run();
   end

   initial begin
      cyc(11);
      chk({1'b0, ratio_oe_n}, {1'b0, RATIO_RST_VAL});
      chk(status, 5'h0A);
      cyc(1);
      srst = 0;
      $display("test reset done");
      // code pins follow the fuses within two cycles while on the ring
      foreach (rows[i]) begin
         ratio_fuse = rows[i].ratio;
         volt_fuse = rows[i].volt;
         cyc(2);
         chk({1'b0, ratio_oe_n}, {1'b0, rows[i].ratio_exp});
         chk(volt_oe_n, rows[i].volt_exp);
      end
      $display("test codes done");
      // cold boot: grid waits for supply-good, then moves to the pll
      go = 1;
      for (int k = 0; k < 20 && supplies_good !== 1'b1; k++) cyc(1);
      cyc(3);
      chk({4'h0, grid_on_pll}, 5'h00);
      cyc(2);
      chk({4'h0, grid_on_pll}, 5'h01);
      cyc(7);
      chk({3'h0, core_hold, proc_ready_flag}, 5'h02);
      cyc(5);
      chk({2'h0, core_hold, proc_ready_flag, fwd_clk_init}, 5'h02);
      chk(pulses[4:0], 5'h00);
      cyc(25);
      chk({early[1:0], pulses[2:0]}, 5'h01);
      $display("test boot done");
      // supply-good glitch and new fuse: no grid return, voltage frozen
      drop = 1;
      volt_fuse = 5'h1F;
      cyc(10);
      chk({4'h0, grid_on_pll}, 5'h01);
      chk(volt_oe_n, 5'h0A);
      // warm reset: core held, code valid after reset asserts
      go = 0;
      ratio_fuse = 4'h6;
      cyc(2);
      chk({1'b0, ratio_oe_n}, 5'h06);
      cyc(4);
      chk({2'h0, grid_on_pll, core_hold, proc_ready_flag}, 5'h06);
      $display("test warm done");
      // synchronous reset in mid-run
      srst = 1;
      cyc(2);
      chk(status, 5'h0A);
      chk(volt_oe_n, VOLT_RST_VAL);
      srst = 0;
      // pin filters restart with reset asserted: no false release edge
      cyc(4);
      chk(status, 5'h0A);
      $display("test rerun reset done");
      complete_run();
   end
endmodule

`default_nettype wire
